// ==== tpd_pkg.sv ====
package tpd_pkg;
    // ***********************************************************
    // register map (byte addresses)
    // ***********************************************************
    localparam logic [7:0] ADDR_CTL0 = 8'h00;
    localparam logic [7:0] ADDR_CTL1 = 8'h04;
    localparam logic [7:0] ADDR_CHCTL0 = 8'h18;
    localparam logic [7:0] ADDR_CHCTL2 = 8'h20;
    localparam logic [7:0] ADDR_CV0 = 8'h34;
    localparam logic [7:0] ADDR_CV3 = 8'h40;
    localparam logic [7:0] ADDR_PROTECTION_LEVEL = 8'h44;
    localparam logic [7:0] ADDR_DCFG = 8'h48;
    localparam logic [7:0] ADDR_DWIN = 8'h4c;
    localparam logic [7:0] ADDR_XCFG = 8'hfc;
    localparam logic [7:0] ADDR_EVT = 8'h14;
    // ***********************************************************
    // field positions
    // ***********************************************************
    localparam int POS_PRIMARY_OUTPUT_ENABLE = 15;
    localparam int POS_AUTOMATIC_OUTPUT_ENABLE = 14;
    localparam int POS_BREAK_POLARITY = 13;
    localparam int POS_BREAK_ENABLE = 12;
    localparam int POS_ROS = 11;
    localparam int POS_IOS = 10;
    localparam int POS_PROTECTION_LEVEL = 8;
    localparam int POS_BCNT = 8;
    localparam int POS_CLOCK_DIVISION = 8;
    localparam int POS_SKIP = 1;
    localparam int POS_OSEL = 0;
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_1 = 2'h1;
    localparam logic [1:0] LVL_2 = 2'h2;
    localparam logic [4:0] BCNT_MAX = 5'h11;
    localparam logic [31:0] RST_VAL = 32'h0000_0000;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : tpd_pkg

// ==== tpd_deadtime.sv ====
`timescale 1ns/10ps
// dead-time length in timer clocks from field and clock division
module tpd_deadtime
    import tpd_pkg::*;
(
    input wire logic [7:0] field,
    input wire logic [1:0] clock_division,
    output logic [15:0] ticks
);
    logic [11:0] dts;
    // ***********************************************************
    // decode
    // ***********************************************************
    always_comb
    begin
        unique casez (field[7:5])
            3'b0??: dts = {4'h0, field};
            3'b10?: dts = {4'h0, 2'h1, field[5:0]} << 1;
            3'b110: dts = {7'h01, field[4:0]} << 3;
            default: dts = {7'h01, field[4:0]} << 4;
        endcase
        // dead-time clock period is 1, 2 or 4 timer clocks
        unique case (clock_division)
            2'h1: ticks = {3'h0, dts, 1'b0};
            2'h2: ticks = {2'h0, dts, 2'h0};
            default: ticks = {4'h0, dts};
        endcase
    end
endmodule : tpd_deadtime

// ==== tpd_top.sv ====
`timescale 1ns/10ps
module tpd_top
    import tpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic update_event,
    input wire logic fault_in,
    input wire logic [3:0] channel_drive,
    output logic [3:0] channel_output,
    output logic [3:0] channel_comp_output,
    output logic [3:0] output_active,
    output logic [15:0] dead_time_ticks,
    output logic dma_request
);
    // ***********************************************************
    // state
    // ***********************************************************
    logic [31:0] ctl0, ctl1, chctl0, chctl2, protection_level, dcfg, xcfg;
    logic [15:0] cval [4];
    logic protection_level_written, aw_held, w_held, bvalid, rvalid, dma_busy;
    logic [7:0] aw_addr;
    logic [31:0] w_data, rdata;
    logic [1:0] bresp;
    logic [4:0] xfer_idx;
    logic [31:0] next_ctl0, next_ctl1, next_chctl0, next_chctl2, next_protection_level;
    logic [31:0] next_dcfg, next_xcfg, next_rdata;
    logic [15:0] next_cval [4];
    logic next_protection_level_written, next_aw_held, next_w_held, next_bvalid;
    logic next_rvalid, next_dma_busy;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [1:0] next_bresp;
    logic [4:0] next_xfer_idx;
    logic do_wr, do_rd, win_wr, win_rd;
    logic [7:0] wr_eff, rd_eff, win_addr;
    logic [1:0] lvl;
    assign lvl = protection_level[POS_PROTECTION_LEVEL+:2];
    // window target: start index words plus transfer index words
    assign win_addr = {1'b0, dcfg[4:0] + xfer_idx, 2'h0};
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = RESP_OK;
    assign dma_request = dma_busy;
    // ***********************************************************
    // write decode and protection
    // ***********************************************************
    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
        end
        do_wr = next_aw_held && next_w_held && !bvalid;
        win_wr = do_wr && next_aw_addr == ADDR_DWIN;
        wr_eff = win_wr ? win_addr : next_aw_addr;
        next_ctl0 = ctl0;
        next_ctl1 = ctl1;
        next_chctl0 = chctl0;
        next_chctl2 = chctl2;
        next_protection_level = protection_level;
        next_dcfg = dcfg;
        next_xcfg = xcfg;
        next_cval = cval;
        next_protection_level_written = protection_level_written;
        next_bvalid = bvalid && !s_axi_bready;
        next_bresp = bresp;
        if (do_wr)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OK;
            unique case (wr_eff)
                ADDR_CTL0: next_ctl0 = next_w_data & 32'h0000_0300;
                ADDR_CTL1: // isolation bits locked from level 01
                    if (lvl == LVL_NONE) next_ctl1 = next_w_data;
                ADDR_CHCTL0: // compare mode locked at level 11
                    if (lvl != 2'h3) next_chctl0 = next_w_data;
                ADDR_CHCTL2: // polarities locked from level 10
                    if (!lvl[1]) next_chctl2 = next_w_data;
                    else next_chctl2 = (chctl2 & 32'h0000_aaaa)
                        | (next_w_data & 32'h0000_5555);
                ADDR_PROTECTION_LEVEL:
                begin
                    next_protection_level[POS_PRIMARY_OUTPUT_ENABLE] = next_w_data[POS_PRIMARY_OUTPUT_ENABLE];
                    if (lvl == LVL_NONE)
                    begin
                        next_protection_level[7:0] = next_w_data[7:0];
                        next_protection_level[POS_BREAK_ENABLE+:3] =
                            next_w_data[POS_BREAK_ENABLE+:3];
                    end
                    if (!lvl[1])
                        next_protection_level[POS_IOS+:2] =
                            next_w_data[POS_IOS+:2];
                    if (!protection_level_written)
                        next_protection_level[POS_PROTECTION_LEVEL+:2] =
                            next_w_data[POS_PROTECTION_LEVEL+:2];
                    next_protection_level_written = 1'b1;
                end
                ADDR_DCFG:
                begin
                    next_dcfg = next_w_data & 32'h0000_1f1f;
                    if (next_dcfg[POS_BCNT+:5] > BCNT_MAX)
                        next_dcfg[POS_BCNT+:5] = BCNT_MAX;
                end
                ADDR_XCFG: next_xcfg = next_w_data & 32'h0000_0003;
                default:
                    if (wr_eff >= ADDR_CV0 && wr_eff <= ADDR_CV3)
                    begin
                        // equal-value writes skipped on request
                        if (!(xcfg[POS_SKIP] && next_w_data[15:0]
                            == cval[wr_eff[3:2]-2'h1]))
                            next_cval[wr_eff[3:2]-2'h1] =
                                next_w_data[15:0];
                    end
                    else if (wr_eff != ADDR_EVT)
                        next_bresp = RESP_ERR;
            endcase
        end
        // hardware set/clear of primary enable; fault wins
        if (update_event && protection_level[POS_AUTOMATIC_OUTPUT_ENABLE])
            next_protection_level[POS_PRIMARY_OUTPUT_ENABLE] = 1'b1;
        if (fault_in && protection_level[POS_BREAK_ENABLE])
            next_protection_level[POS_PRIMARY_OUTPUT_ENABLE] = 1'b0;
    end
    // ***********************************************************
    // read path and burst index
    // ***********************************************************
    always_comb
    begin
        do_rd = s_axi_arvalid && s_axi_arready;
        win_rd = do_rd && s_axi_araddr == ADDR_DWIN;
        rd_eff = win_rd ? win_addr : s_axi_araddr;
        next_rvalid = (rvalid && !s_axi_rready) || do_rd;
        next_rdata = rdata;
        if (do_rd)
        begin
            unique case (rd_eff)
                ADDR_CTL0: next_rdata = ctl0;
                ADDR_CTL1: next_rdata = ctl1;
                ADDR_CHCTL0: next_rdata = chctl0;
                ADDR_CHCTL2: next_rdata = chctl2;
                ADDR_PROTECTION_LEVEL: next_rdata = protection_level;
                ADDR_DCFG: next_rdata = dcfg;
                ADDR_XCFG: next_rdata = xcfg;
                default:
                    if (rd_eff >= ADDR_CV0 && rd_eff <= ADDR_CV3)
                        next_rdata = {16'h0, cval[rd_eff[3:2]-2'h1]};
                    else
                        next_rdata = RST_VAL;
            endcase
        end
        next_dma_busy = dma_busy;
        next_xfer_idx = xfer_idx;
        // request raised by the update event and held through the burst;
        // the partner moves one word per finished access while it stands
        if (win_wr || win_rd)
        begin
            if (xfer_idx == dcfg[POS_BCNT+:5])
            begin
                next_xfer_idx = 5'h00;
                next_dma_busy = 1'b0;
            end
            else
                next_xfer_idx = xfer_idx + 5'h01;
        end
        else if (update_event && !dma_busy)
            next_dma_busy = 1'b1;
    end
    // ***********************************************************
    // registers
    // ***********************************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctl0 <= RST_VAL;
            ctl1 <= RST_VAL;
            chctl0 <= RST_VAL;
            chctl2 <= RST_VAL;
            protection_level <= RST_VAL;
            dcfg <= RST_VAL;
            xcfg <= RST_VAL;
            cval <= '{default: 16'h0000};
            protection_level_written <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= RST_VAL;
            bvalid <= 1'b0;
            bresp <= RESP_OK;
            rvalid <= 1'b0;
            rdata <= RST_VAL;
            dma_busy <= 1'b0;
            xfer_idx <= 5'h00;
        end
        else
        begin
            ctl0 <= next_ctl0;
            ctl1 <= next_ctl1;
            chctl0 <= next_chctl0;
            chctl2 <= next_chctl2;
            protection_level <= next_protection_level;
            dcfg <= next_dcfg;
            xcfg <= next_xcfg;
            cval <= next_cval;
            protection_level_written <= next_protection_level_written;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            dma_busy <= next_dma_busy;
            xfer_idx <= next_xfer_idx;
        end
    end
    // ***********************************************************
    // output stage
    // ***********************************************************
    logic [3:0] out_q, comp_q, act_q;
    logic outs_on;
    // output select only forces off what a clear idle state already
    // disables, so a set idle state keeps its outputs regardless
    always_comb
    begin
        if (protection_level[POS_PRIMARY_OUTPUT_ENABLE])
            outs_on = protection_level[POS_ROS];
        else
            outs_on = protection_level[POS_IOS];
    end
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            out_q <= 4'h0;
            comp_q <= 4'h0;
            act_q <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                act_q[i] <= outs_on && (chctl2[4*i] || chctl2[4*i+2]);
                out_q[i] <= outs_on && chctl2[4*i]
                    && (channel_drive[i] ^ chctl2[4*i+1]);
                comp_q[i] <= outs_on && chctl2[4*i+2]
                    && (!channel_drive[i] ^ chctl2[4*i+3]);
            end
        end
    end
    assign channel_output = out_q;
    assign channel_comp_output = comp_q;
    assign output_active = act_q;
    tpd_deadtime u_dt (
        .field(protection_level[7:0]),
        .clock_division(ctl0[POS_CLOCK_DIVISION+:2]),
        .ticks(dead_time_ticks)
    );
    // ***********************************************************
    // checks
    // ***********************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    protection_level_once_a: assert property ($past(protection_level_written) && !$past(rst)
        |-> protection_level[9:8] == $past(protection_level[9:8]))
        else $error("protection level changed twice");
    dt_lock_a: assert property (lvl != LVL_NONE |=> protection_level[7:0]
        == $past(protection_level[7:0]))
        else $error("dead time changed while locked");
    ios_lock_a: assert property (lvl[1] |=> protection_level[POS_IOS]
        == $past(protection_level[POS_IOS]))
        else $error("idle state changed while locked");
    brk_lock_a: assert property (lvl != LVL_NONE |=> protection_level[14:12]
        == $past(protection_level[14:12]))
        else $error("break fields changed while locked");
    bcnt_range_a: assert property (dcfg[12:8] <= BCNT_MAX)
        else $error("burst count out of range");
    dcfg_rsv_a: assert property ((dcfg & 32'hffff_e0e0) == 0)
        else $error("reserved config bits set");
    idx_range_a: assert property (xfer_idx <= dcfg[12:8]
        || $changed(dcfg))
        else $error("transfer index past count");
    osel_off_a: assert property (!protection_level[POS_PRIMARY_OUTPUT_ENABLE] && !protection_level[POS_IOS] && xcfg[0]
        |=> output_active == 4'h0)
        else $error("outputs not forced off");
    idle_off_a: assert property (!protection_level[POS_PRIMARY_OUTPUT_ENABLE] && !protection_level[POS_IOS]
        |=> channel_output == 4'h0)
        else $error("idle outputs not off");
    primary_output_enable_fault_a: assert property (fault_in && protection_level[POS_BREAK_ENABLE]
        |=> !protection_level[POS_PRIMARY_OUTPUT_ENABLE])
        else $error("fault did not clear primary enable");
    win_step_a: assert property (win_rd && xfer_idx != dcfg[12:8]
        |=> xfer_idx == $past(xfer_idx) + 5'h01)
        else $error("window index did not advance");
    skip_cov: cover property (do_wr && xcfg[1]);
    burst_cov: cover property (dma_busy ##1 !dma_busy);
    lock_cov: cover property (lvl == 2'h3);
endmodule : tpd_top

// ==== tpd_dma_model.sv ====
`timescale 1ns/10ps
// ***********************************************************
// system dma stand-in, sole master of the register bus
// ***********************************************************
module tpd_dma_model
    import tpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic dma_request,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    logic [31:0] got [0:31];

    // idle bus at time zero; word access only, so all strobes stay on
    // response readies stay high, so back-to-back calls never flip them
    initial
    begin
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
    end

    // address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask : wr

    // single read, data taken at the edge that shows rvalid
    task rd(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
    endtask : rd

    // one window access per requested word, each finished before
    // the next; stall gaps mimic a busy system bus
    task serve(input logic write, input logic [31:0] base, input int n,
               input int stall);
        logic [1:0] r;
        for (int i = 0; i < n; i++)
        begin
            while (dma_request !== 1'b1)
                @(posedge clk_sys);
            repeat (stall) @(posedge clk_sys);
            if (write)
                wr(ADDR_DWIN, base + 32'(i), r);
            else
                rd(ADDR_DWIN, got[i]);
        end
    endtask : serve
endmodule : tpd_dma_model

// ==== tpd_tb_top.sv ====
`timescale 1ns/10ps
module tpd_tb_top
    import tpd_pkg::*;
;
    typedef struct {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic [15:0] dt;
    } tpd_row_s;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic update_event = 1'b0;
    logic fault_in = 1'b0;
    logic [3:0] channel_drive = 4'h5;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata, q, eq;
    logic [3:0] s_axi_wstrb, channel_output, channel_comp_output;
    logic [3:0] output_active;
    logic [1:0] s_axi_bresp, resp, rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, dma_request;
    logic [15:0] dead_time_ticks;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] ra [4] = '{ADDR_PROTECTION_LEVEL, ADDR_DCFG, ADDR_DWIN, ADDR_XCFG};
    // clock_division starts at one clock, then four, later two; 0x44 rows lock level at 00
    tpd_row_s rows [12] = '{
        '{8'h44, 32'h0000_0005, 32'h0000_0005, 16'h0005},
        '{8'h44, 32'h0000_00a3, 32'h0000_00a3, 16'h00c6},
        '{8'h44, 32'h0000_00c7, 32'h0000_00c7, 16'h0138},
        '{8'h44, 32'h0000_00ff, 32'h0000_00ff, 16'h03f0},
        '{8'h44, 32'h0000_007f, 32'h0000_007f, 16'h007f},
        '{8'h00, 32'h0000_0200, 32'h0000_0200, 16'h01fc},
        '{8'h00, 32'h0000_0100, 32'h0000_0100, 16'h00fe},
        '{8'h44, 32'h0000_0380, 32'h0000_0080, 16'h0100},
        '{8'h48, 32'hffff_ffff, 32'h0000_111f, 16'h0100},
        '{8'hfc, 32'hffff_ffff, 32'h0000_0003, 16'h0100},
        '{8'hfc, 32'h0000_0000, 32'h0000_0000, 16'h0100},
        '{8'h80, 32'h0000_0001, 32'h0000_0000, 16'h0100}};

    // ***********************************************************
    // clock, design and bus partner
    // ***********************************************************
    always #20 clk_sys = ~clk_sys;

    tpd_top dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp(rresp), .s_axi_rvalid, .s_axi_rready, .update_event,
        .fault_in, .channel_drive, .channel_output,
        .channel_comp_output, .output_active, .dead_time_ticks,
        .dma_request);

    tpd_dma_model u_dma (.clk_sys, .dma_request, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

    // ***********************************************************
    // helpers
    // ***********************************************************
    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task results();
        if (errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    // write then read back the same word
    task acc(input logic [7:0] a, input logic [31:0] d);
        u_dma.wr(a, d, resp);
        u_dma.rd(a, q);
    endtask : acc

    // a change seen at one edge reaches the pins one edge later; look
    // at the third so the single output stage has settled
    task outs(input logic [3:0] exp);
        repeat (3) @(posedge clk_sys);
        check("active", {28'h0, output_active}, {28'h0, exp});
        check("out", {28'h0, channel_output},
              {28'h0, exp & channel_drive});
        check("comp", {28'h0, channel_comp_output},
              {28'h0, exp & ~channel_drive});
    endtask : outs

    // hang guard: far above the under two hundred cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end

    // ***********************************************************
    // main sequence
    // ***********************************************************
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        foreach (rows[i])
        begin
            acc(rows[i].a, rows[i].d);
            eq = (rows[i].a == 8'h80) ? 32'(RESP_ERR) : 32'(RESP_OK);
            check("resp", {30'h0, resp}, eq);
            check("rresp", {30'h0, rresp}, 32'(RESP_OK));
            check("read", q, rows[i].q);
            check("dead", {16'h0, dead_time_ticks}, {16'h0, rows[i].dt});
        end
        // output gating by primary enable, idle state and fault
        u_dma.wr(ADDR_CHCTL2, 32'h0000_5555, resp);
        u_dma.wr(ADDR_PROTECTION_LEVEL, 32'h0000_0400, resp);
        outs(4'hf);
        u_dma.wr(ADDR_XCFG, 32'h0000_0001, resp);
        outs(4'hf);
        u_dma.wr(ADDR_PROTECTION_LEVEL, 32'h0000_0000, resp);
        outs(4'h0);
        u_dma.wr(ADDR_XCFG, 32'h0000_0000, resp);
        u_dma.wr(ADDR_PROTECTION_LEVEL, 32'h0000_9800, resp);
        outs(4'hf);
        fault_in <= 1'b1;
        outs(4'h0);
        u_dma.rd(ADDR_PROTECTION_LEVEL, q);
        check("fault", q, 32'h0000_1800);
        u_dma.wr(ADDR_PROTECTION_LEVEL, 32'h0000_5800, resp);
        fault_in <= 1'b0;
        // update sets the enable and starts a three word burst at cv0
        u_dma.wr(ADDR_DCFG, 32'h0000_020d, resp);
        update_event <= 1'b1;
        @(posedge clk_sys);
        update_event <= 1'b0;
        u_dma.serve(1'b1, 32'h0000_a000, 3, 0);
        outs(4'hf);
        check("req", {31'h0, dma_request}, 32'h0);
        u_dma.rd(ADDR_PROTECTION_LEVEL, q);
        check("auto", q, 32'h0000_d800);
        for (int k = 0; k < 4; k++)
        begin
            u_dma.rd(ADDR_CV0 + 8'(4 * k), q);
            eq = (k < 3) ? 32'h0000_a000 + 32'(k) : 32'h0;
            check("cv", q, eq);
        end
        update_event <= 1'b1;
        @(posedge clk_sys);
        update_event <= 1'b0;
        u_dma.serve(1'b0, 32'h0, 3, 2);
        for (int k = 0; k < 3; k++)
            check("win", u_dma.got[k], 32'h0000_a000 + 32'(k));
        // second reset, then a level 10 lock
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        foreach (ra[i])
        begin
            u_dma.rd(ra[i], q);
            check("reset", q, RST_VAL);
        end
        acc(ADDR_PROTECTION_LEVEL, 32'h0000_0210);
        check("lvl", q, 32'h0000_0210);
        acc(ADDR_PROTECTION_LEVEL, 32'h0000_8633);
        check("lock", q, 32'h0000_8210);
        check("dead", {16'h0, dead_time_ticks}, 32'h0000_0010);
        acc(ADDR_CHCTL2, 32'h0000_ffff);
        check("pol", q, 32'h0000_5555);
        acc(ADDR_CTL1, 32'h0000_00ff);
        check("iso", q, 32'h0000_0000);
        results();
    end
endmodule : tpd_tb_top
